// file: logic/console_cfg.svh
// Constants for the console register access block.
// Assumes inclusion by bare name from the package and the block.
`ifndef CONSOLE_CFG_SVH
`define CONSOLE_CFG_SVH

`define CON_DW          16
`define CON_GP_N        8
`define CON_RF_N        20
`define CON_IDX_W       5
// Flat register file: 0..7 background bank, 8..15 foreground bank.
`define CON_IDX_BG0     5'h00
`define CON_IDX_FG0     5'h08
`define CON_IDX_IR      5'h10
`define CON_IDX_WR      5'h11
`define CON_IDX_PC      5'h12
`define CON_IDX_ST      5'h13
// Bit of the status register that selects the foreground bank.
`define CON_ST_FG_BIT   8
`define CON_RST_VAL     16'h0000
// Avalon byte addresses, one aligned 32-bit word each.
`define CON_AV_AW       5
`define CON_OFS_STAT    5'h00
`define CON_OFS_DISP    5'h04
`define CON_OFS_MDR     5'h08
`define CON_OFS_INDEX   5'h0C
`define CON_OFS_DATA    5'h10
// Fields of the console state word.
`define CON_STAT_KEY    0
`define CON_STAT_IDLE   1
`define CON_STAT_FG     2
`define CON_STAT_SEL_LO 4
`define CON_STAT_SEL_HI 6
`define CON_STAT_BUSY   8

`endif

// file: logic/console_pkg.sv
// Types shared by the console register access block.
// Assumes console_cfg.svh is on the include path.
`include "console_cfg.svh"

package console_pkg;
   typedef logic [`CON_DW-1:0]    word_t;
   typedef logic [`CON_IDX_W-1:0] idx_t;

   // Register chosen by the console select switches.
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_IR   = 3'b001,
      SEL_WR   = 3'b010,
      SEL_PC   = 3'b011,
      SEL_ST   = 3'b100,
      SEL_GP   = 3'b101
   } sel_t;

   // Instruction register load goes through the memory data register.
   typedef enum logic [0:0] {
      IRS_IDLE = 1'b0,
      IRS_LOAD = 1'b1
   } irs_t;
endpackage

// file: logic/console_regs.sv
// Console access to the processor register set: keyed entry, display
// register and foreground/background bank switching, plus an Avalon-MM
// slave that lets software read state and reach every register.
// Assumes console switch pins are asynchronous and debounced outside.
//
// How it works
// - Key lock disabled ignores every console switch.
// - Status written zero selects background bank.
// - Every console register holds sixteen bits.
// - Enter loads entry value, then displays it.
// - Select code 000..111 maps eight registers.
// - Program counter bit 15 may not stick.
// - Foreground bank exists, chosen by status 0100.
// - Display reads only the selected bank.
// - Selecting alone displays present register contents.
// - Instruction writes go through memory data register.
// - Other writes ride augend bus, ALU, data bus.
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "console_cfg.svh"

module console_regs
   import console_pkg::*;
#(
   parameter logic [`CON_DW-1:0] PC_KEEP = 16'hFFFF,
   parameter bit                 IDLE_ONLY = 1'b1
)
(
   input  wire logic                     i_clk,
   input  wire logic                     i_sys_rst,
   input  wire logic                     i_key_enable,
   input  wire logic                     i_run_idle_n,
   input  wire logic [`CON_DW-1:0]       i_data_entry,
   input  wire logic                     i_sel_ir,
   input  wire logic                     i_sel_wr,
   input  wire logic                     i_sel_pc,
   input  wire logic                     i_sel_st,
   input  wire logic                     i_sel_gp,
   input  wire logic [2:0]               i_gp_sel,
   input  wire logic                     i_enter,
   output logic [`CON_DW-1:0]            o_display,
   output logic                          o_bank_fg,
   input  wire logic [`CON_AV_AW-1:0]    i_avs_address,
   input  wire logic                     i_avs_read,
   input  wire logic                     i_avs_write,
   input  wire logic [31:0]              i_avs_writedata,
   input  wire logic [3:0]               i_avs_byteenable,
   output logic [31:0]                   o_avs_readdata,
   output logic                          o_avs_waitrequest
);
   import console_pkg::*;

   localparam int SW_W = `CON_DW + 3 + 5 + 3;

   // Merge a 32-bit Avalon write into a 16-bit register by byte lane.
   function automatic word_t lane_merge(input word_t old, input logic [31:0] wd, input logic [3:0] be);
      word_t r;
      r = old;
      if (be[0])
      begin
         r[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   // Flat index of the register behind a select code and bank.
   function automatic idx_t reg_index(input sel_t s, input logic fg, input logic [2:0] gp);
      idx_t r;
      r = `CON_IDX_IR;
      unique case (s)
         SEL_IR:   r = `CON_IDX_IR;
         SEL_WR:   r = `CON_IDX_WR;
         SEL_PC:   r = `CON_IDX_PC;
         SEL_ST:   r = `CON_IDX_ST;
         SEL_GP:   r = (fg ? `CON_IDX_FG0 : `CON_IDX_BG0) | idx_t'(gp);
         SEL_NONE: r = `CON_IDX_IR;
         default:  r = `CON_IDX_IR;
      endcase
      return r;
   endfunction

   // Two-stage synchronisers for every switch pin.
   logic [SW_W-1:0] sw_meta_q;
   logic [SW_W-1:0] sw_q;
   logic            enter_last_q;
   logic            key_s;
   logic            idle_s;
   logic            enter_s;
   word_t           entry_s;
   logic [2:0]      gp_s;
   logic [4:0]      sels_s;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sw_meta_q    <= '0;
         sw_q         <= '0;
         enter_last_q <= 1'b0;
      end
      else
      begin
         sw_meta_q    <= {i_key_enable, i_run_idle_n, i_enter, i_gp_sel,
                          i_sel_ir, i_sel_wr, i_sel_pc, i_sel_st, i_sel_gp, i_data_entry};
         sw_q         <= sw_meta_q;
         enter_last_q <= enter_s;
      end
   end

   assign key_s   = sw_q[SW_W-1];
   assign idle_s  = ~sw_q[SW_W-2];
   assign enter_s = sw_q[SW_W-3];
   assign gp_s    = sw_q[SW_W-4 -: 3];
   assign sels_s  = sw_q[`CON_DW +: 5];
   assign entry_s = sw_q[`CON_DW-1:0];

   // Console selection; a locked key masks every switch.
   sel_t  sel;
   logic  bank_fg;
   idx_t  con_idx;
   logic  enter_pls;
   logic  con_go;
   logic  con_we;
   logic  con_ir;

   assign sel = !key_s     ? SEL_NONE :
                sels_s[4] ? SEL_IR :
                sels_s[3] ? SEL_WR :
                sels_s[2] ? SEL_PC :
                sels_s[1] ? SEL_ST :
                sels_s[0] ? SEL_GP : SEL_NONE;
   assign con_idx   = reg_index(sel, bank_fg, gp_s);
   assign enter_pls = enter_s & ~enter_last_q;
   // Entry while the processor runs would race its own writes, so refuse it.
   assign con_go    = key_s & enter_pls & (sel != SEL_NONE) & (idle_s | !IDLE_ONLY);
   assign con_we    = con_go & (sel != SEL_IR);
   assign con_ir    = con_go & (sel == SEL_IR);

   // Augend bus into the ALU, pass-through add of a zero addend, onto the data bus.
   word_t augend_bus;
   word_t addend_bus;
   word_t alu_out;
   word_t data_bus;
   word_t con_val;

   assign augend_bus = entry_s;
   assign addend_bus = `CON_RST_VAL;
   assign alu_out    = augend_bus + addend_bus;
   assign data_bus   = alu_out;
   assign con_val    = (con_idx == `CON_IDX_PC) ? (data_bus & PC_KEEP) : data_bus;

   // Memory data register and the instruction load sequencer.
   word_t mdr_q;
   irs_t  irs_q;
   logic  ir_load;

   // Avalon request decode.
   logic  av_req;
   logic  av_ack_q;
   logic  av_wr;
   idx_t  av_index_q;
   logic  av_idx_ok;
   logic  av_rf_we;
   logic  av_mdr_we;
   logic  av_dec_ok;

   assign av_req    = i_avs_read | i_avs_write;
   assign av_wr     = i_avs_write & av_ack_q;
   assign av_idx_ok = av_index_q < idx_t'(`CON_RF_N);
   assign av_rf_we  = av_wr & (i_avs_address == `CON_OFS_DATA) & av_idx_ok;
   assign av_mdr_we = av_wr & (i_avs_address == `CON_OFS_MDR);
   assign ir_load   = (irs_q == IRS_LOAD);

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         mdr_q <= `CON_RST_VAL;
         irs_q <= IRS_IDLE;
      end
      else
      begin
         if (con_ir)
         begin
            mdr_q <= entry_s;
         end
         else if (av_mdr_we)
         begin
            mdr_q <= lane_merge(mdr_q, i_avs_writedata, i_avs_byteenable);
         end
         unique case (irs_q)
            IRS_IDLE: irs_q <= con_ir ? IRS_LOAD : IRS_IDLE;
            IRS_LOAD: irs_q <= IRS_IDLE;
         endcase
      end
   end

   // Register file; each entry has its own enable so writes never disturb others.
   word_t rf_q [`CON_RF_N];

   always_ff @(posedge i_clk)
   begin
      for (int k = 0; k < `CON_RF_N; k++)
      begin
         if (i_sys_rst)
         begin
            rf_q[k] <= `CON_RST_VAL;
         end
         else if (con_we && con_idx == idx_t'(k))
         begin
            rf_q[k] <= con_val;
         end
         else if (ir_load && idx_t'(k) == `CON_IDX_IR)
         begin
            rf_q[k] <= mdr_q;
         end
         else if (av_rf_we && av_index_q == idx_t'(k))
         begin
            rf_q[k] <= lane_merge(rf_q[k], i_avs_writedata, i_avs_byteenable);
         end
      end
   end

   assign bank_fg   = rf_q[`CON_IDX_ST][`CON_ST_FG_BIT];
   assign o_bank_fg = bank_fg;

   // Display register follows whichever register is selected.
   word_t disp_q;
   word_t sel_val;

   assign sel_val = rf_q[con_idx];

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         disp_q <= `CON_RST_VAL;
      end
      else if (sel != SEL_NONE)
      begin
         disp_q <= sel_val;
      end
   end

   assign o_display = disp_q;

   // Avalon slave: one wait state, read data registered at the request edge.
   logic [31:0] stat_word;
   logic [31:0] rd_mux;

   assign stat_word = {23'h000000, ir_load, 1'b0, sel, 1'b0, bank_fg, idle_s, key_s};
   assign av_dec_ok = (i_avs_address == `CON_OFS_STAT) | (i_avs_address == `CON_OFS_DISP) |
                      (i_avs_address == `CON_OFS_MDR) | (i_avs_address == `CON_OFS_INDEX) |
                      (i_avs_address == `CON_OFS_DATA);
   assign rd_mux = !av_dec_ok ? 32'h00000000 :
                   (i_avs_address == `CON_OFS_STAT)  ? stat_word :
                   (i_avs_address == `CON_OFS_DISP)  ? {16'h0000, disp_q} :
                   (i_avs_address == `CON_OFS_MDR)   ? {16'h0000, mdr_q} :
                   (i_avs_address == `CON_OFS_INDEX) ? {27'h0000000, av_index_q} :
                   av_idx_ok ? {16'h0000, rf_q[av_index_q]} : 32'h00000000;
   assign o_avs_waitrequest = av_req & ~av_ack_q;

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         av_ack_q       <= 1'b0;
         av_index_q     <= '0;
         o_avs_readdata <= 32'h00000000;
      end
      else
      begin
         av_ack_q <= av_req & ~av_ack_q;
         if (i_avs_read && !av_ack_q)
         begin
            o_avs_readdata <= rd_mux;
         end
         if (av_wr && i_avs_address == `CON_OFS_INDEX && i_avs_byteenable[0])
         begin
            av_index_q <= i_avs_writedata[`CON_IDX_W-1:0];
         end
      end
   end

   // Checks on the design's own behaviour.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   key_lock_a: assert property (!key_s |=> $stable(disp_q))
      else $error("display changed while key lock disabled");
   key_no_write_a: assert property (!key_s |-> !con_go)
      else $error("console entry accepted while key lock disabled");
   idle_gate_a: assert property (!idle_s && IDLE_ONLY |-> !con_go)
      else $error("console entry accepted while running");
   bg_select_a: assert property (con_we && sel == SEL_ST && entry_s == 16'h0000 |=> !bank_fg)
      else $error("zero status did not select background bank");
   fg_select_a: assert property (con_we && sel == SEL_ST && entry_s == 16'h0100 |=> bank_fg)
      else $error("status 0100 did not select foreground bank");
   gp_width_a: assert property (con_we && sel == SEL_GP |=> rf_q[$past(con_idx)] == $past(entry_s))
      else $error("general register lost bits of entry value");
   enter_show_a: assert property (con_we && sel == SEL_GP ##1 ($stable(con_idx) && key_s && !av_rf_we)
                                  |=> disp_q == $past(entry_s, 2))
      else $error("entered value not shown on display");
   bank_map_a: assert property (sel == SEL_GP |-> con_idx == {1'b0, bank_fg, gp_s})
      else $error("general register select mapped wrongly");
   pc_mask_a: assert property (con_we && sel == SEL_PC |=> rf_q[`CON_IDX_PC] == ($past(entry_s) & PC_KEEP))
      else $error("program counter took wrong value");
   show_sel_a: assert property (sel != SEL_NONE |=> disp_q == $past(sel_val))
      else $error("display did not follow selected register");
   ir_path_a: assert property (con_ir |=> mdr_q == $past(entry_s) ##1 rf_q[`CON_IDX_IR] == $past(mdr_q))
      else $error("instruction register not loaded through memory data register");
   hold_other_a: assert property (con_we && con_idx != `CON_IDX_WR && !av_rf_we |=> $stable(rf_q[`CON_IDX_WR]))
      else $error("working register changed by another write");

   // Slave port: each request sees exactly one wait state.
   // A master that drops its request early still leaves one acknowledge cycle behind, so it must hold it.
   one_wait_a: assert property (av_req && !av_ack_q |-> o_avs_waitrequest ##1 (av_ack_q && !o_avs_waitrequest))
      else $error("bus request not answered after one wait state");
   read_data_a: assert property (i_avs_read && !av_ack_q |=> o_avs_readdata == $past(rd_mux))
      else $error("read data not captured at the request edge");
   unmapped_read_a: assert property (i_avs_read && !av_ack_q && !av_dec_ok |=> o_avs_readdata == 32'h00000000)
      else $error("unmapped address did not read zero");
   index_write_a: assert property (av_wr && i_avs_address == `CON_OFS_INDEX && i_avs_byteenable[0]
                                   |=> av_index_q == $past(i_avs_writedata[`CON_IDX_W-1:0]))
      else $error("index register did not take written value");

   // Console side: one press gives one load, and the display freezes when nothing is selected.
   enter_once_a: assert property (enter_pls |=> !enter_pls)
      else $error("one press gave two entry pulses");
   disp_hold_a: assert property (sel == SEL_NONE |=> $stable(disp_q))
      else $error("display changed with nothing selected");
   mdr_hold_a: assert property (!con_ir && !av_mdr_we |=> $stable(mdr_q))
      else $error("memory data register changed without a write");
   ir_load_once_a: assert property (ir_load |=> !ir_load)
      else $error("instruction load sequencer did not return to idle");
endmodule

// file: tb/console_operator.sv
// Behavioural operator at the front panel: key lock, run/idle and switches.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
module console_operator
(
   input  wire logic   i_clk,
   output logic        o_key_enable,
   output logic        o_run_idle_n,
   output logic [15:0] o_data_entry,
   output logic [4:0]  o_sel,
   output logic [2:0]  o_gp_sel,
   output logic        o_enter
);
   initial
   begin
      o_key_enable = 1'b0;
      o_run_idle_n = 1'b0;
      o_data_entry = 16'h0000;
      o_sel = 5'h00;
      o_gp_sel = 3'h0;
      o_enter = 1'b0;
   end

   task automatic set_key(input logic k);
      @(posedge i_clk);
      o_key_enable <= k;
      repeat (4) @(posedge i_clk);
   endtask

   // The run position is only taken to check that entry is refused while running.
   task automatic set_run(input logic r);
      @(posedge i_clk);
      o_run_idle_n <= r;
      repeat (4) @(posedge i_clk);
   endtask

   // Switches settle through the synchronisers before the button moves, and
   // the button stays released long enough for the edge detector to rearm.
   task automatic press(input logic [4:0] s, input logic [2:0] g, input logic [15:0] v, input logic en);
      @(posedge i_clk);
      o_sel <= s;
      o_gp_sel <= g;
      o_data_entry <= v;
      repeat (4) @(posedge i_clk);
      o_enter <= en;
      repeat (8) @(posedge i_clk);
      o_enter <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
endmodule

// file: tb/tb_console_regs.sv
// Self-checking bench: console loads, bank switching, display by selection
// alone, and software readback of every register over the slave port.
// Assumes console_operator as the front-panel model.
`timescale 1ns/1ns
module tb_console_regs;
   import console_pkg::*;
   logic        i_clk;
   logic        i_sys_rst;
   logic        key;
   logic        run_n;
   logic [15:0] entry;
   logic [4:0]  sel;
   logic [2:0]  gp;
   logic        enter;
   word_t       disp;
   logic        bank;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        waitreq;
   word_t       exp_q [20];
   int          n_errors;
   int          comparisons;
   int          cycles;
   word_t       v;
   logic [31:0] q;

   console_operator op
   (
      .i_clk(i_clk), .o_key_enable(key), .o_run_idle_n(run_n), .o_data_entry(entry),
      .o_sel(sel), .o_gp_sel(gp), .o_enter(enter)
   );

   console_regs dut
   (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_key_enable(key), .i_run_idle_n(run_n),
      .i_data_entry(entry), .i_sel_ir(sel[4]), .i_sel_wr(sel[3]), .i_sel_pc(sel[2]),
      .i_sel_st(sel[1]), .i_sel_gp(sel[0]), .i_gp_sel(gp), .i_enter(enter),
      .o_display(disp), .o_bank_fg(bank), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic test_done;
      if (n_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // The whole run needs about 950 cycles.
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         n_errors++;
         test_done();
      end
   end

   task automatic chk(input word_t got, input word_t want);
      comparisons++;
      if (got !== want)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // Request held until waitrequest is seen low at a rising edge; only the
   // bench timeout ends a wait that never gets its answer.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      do
      begin
         @(posedge i_clk);
      end
      while (waitreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // Bit 15 of the program counter is not guaranteed, so it is masked.
   function automatic word_t seen(input int i, input word_t x);
      return (i == 18) ? (x & 16'h7FFF) : x;
   endfunction

   function automatic logic [4:0] sel_of(input int i);
      return (i >= 16) ? 5'(5'h10 >> (i - 16)) : 5'h01;
   endfunction

   task automatic load(input int i, input word_t val, input logic en);
      op.press(sel_of(i), i[2:0], val, en);
      if (en)
         exp_q[i] = val;
      chk(seen(i, disp), seen(i, exp_q[i]));
   endtask

   initial
   begin
      i_sys_rst = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      foreach (exp_q[i])
         exp_q[i] = 16'h0000;
      q = $urandom(7);
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      op.press(5'h01, 3'h0, 16'hFFFF, 1'b1);
      chk(disp, 16'h0000);
      op.set_key(1'b1);
      load(19, 16'h0100, 1'b1);
      chk({15'h0, bank}, 16'h0001);
      load(19, 16'h0000, 1'b1);
      chk({15'h0, bank}, 16'h0000);
      v = 16'hFFFF;
      for (int k = 0; k < 11; k++)
      begin
         load(k < 3 ? 16 + k : k - 3, v, 1'b1);
         v = v << 1;
      end
      load(19, 16'h0100, 1'b1);
      for (int g = 0; g < 8; g++)
      begin
         q = $urandom;
         load(8 + g, q[15:0], 1'b1);
      end
      for (int g = 0; g < 8; g++)
         load(8 + g, ~exp_q[g], 1'b0);
      load(19, 16'h0000, 1'b1);
      for (int i = 0; i < 19; i++)
      begin
         if (i < 8 || i > 15)
            load(i, ~exp_q[i], 1'b0);
      end
      for (int i = 0; i < 20; i++)
      begin
         bus(1'b1, 5'h0C, 32'(i));
         bus(1'b0, 5'h10, 32'h0);
         chk(seen(i, q[15:0]), seen(i, exp_q[i]));
         chk(q[31:16], 16'h0000);
      end
      bus(1'b0, 5'h14, 32'h0);
      chk(q[15:0], 16'h0000);
      q = $urandom;
      v = q[15:0];
      bus(1'b1, 5'h0C, 32'h00000011);
      bus(1'b1, 5'h10, {16'h0, v});
      exp_q[17] = v;
      load(17, ~v, 1'b0);
      op.set_run(1'b1);
      op.press(5'h08, 3'h0, ~v, 1'b1);
      chk(disp, exp_q[17]);
      op.set_run(1'b0);
      bus(1'b0, 5'h00, 32'h0);
      chk(q[15:0], 16'h0023);
      bus(1'b0, 5'h04, 32'h0);
      chk(q[15:0], exp_q[17]);
      bus(1'b0, 5'h08, 32'h0);
      chk(q[15:0], exp_q[16]);
      op.set_key(1'b0);
      op.press(5'h01, 3'h1, 16'h5A5A, 1'b1);
      chk(disp, exp_q[17]);
      bus(1'b1, 5'h0C, 32'h00000001);
      bus(1'b0, 5'h10, 32'h0);
      chk(q[15:0], exp_q[1]);
      test_done();
   end
endmodule
